/* request_node_filter.sv */
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module request_node_filter (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        link_reset_signal,
  input  wire logic        req_valid,
  input  wire logic [5:0]  req_src_node,
  input  wire logic        req_src_local,
  input  wire logic        req_to_phys,
  input  wire logic [31:0] phys_filter_low,
  output logic             dec_valid,
  output logic             dec_accept,
  output logic      [1:0]  dec_route
);

  // Filter state
  logic [31:0] async_hi_ff;
  logic [31:0] async_lo_ff;
  logic [31:0] phys_hi_ff;
  logic [31:0] nxt_async_hi;
  logic [31:0] nxt_async_lo;
  logic [31:0] nxt_phys_hi;

  // Statistics
  logic [31:0] accept_cnt_ff;
  logic [31:0] reject_cnt_ff;
  logic [31:0] last_dec_ff;
  logic [31:0] nxt_accept_cnt;
  logic [31:0] nxt_reject_cnt;
  logic [31:0] nxt_last_dec;

  // Bus slave state
  filt_pkg::apb_state_t state_ff;
  filt_pkg::apb_state_t nxt_state;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] nxt_prdata;
  logic        nxt_pready;
  logic        nxt_pslverr;

  // Decision outputs
  logic        dec_valid_ff;
  logic        dec_accept_ff;
  logic [1:0]  dec_route_ff;

  // Byte lanes to bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // Read/set/clear update; set and clear addresses never coincide
  function automatic logic [31:0] rsc_next(
    input logic [31:0] cur,
    input logic [31:0] bits,
    input logic        set,
    input logic        clr
  );
    logic [31:0] res;
    res = cur;
    if (set) begin
      res = cur | bits;
    end else if (clr) begin
      res = cur & ~bits;
    end
    rsc_next = res;
  endfunction

  // Address decode
  wire logic        acc_phase;
  wire logic        commit;
  wire logic        wr_commit;
  wire logic [31:0] wbits;
  wire logic        hit_async_hi_set;
  wire logic        hit_async_hi_clr;
  wire logic        hit_async_lo_set;
  wire logic        hit_async_lo_clr;
  wire logic        hit_phys_hi_set;
  wire logic        hit_phys_hi_clr;
  wire logic        hit_accept_cnt;
  wire logic        hit_reject_cnt;
  wire logic        hit_last_dec;
  wire logic        hit_any;
  wire logic [31:0] rd_mux;

  assign acc_phase = psel & penable;
  assign commit    = acc_phase & (state_ff == filt_pkg::APB_ANSWER);
  assign wr_commit = commit & pwrite & ~pslverr_ff;
  assign wbits     = pwdata & strb_mask(pstrb);

  assign hit_async_hi_set = (paddr == filt_pkg::ADDR_ASYNC_HI_SET);
  assign hit_async_hi_clr = (paddr == filt_pkg::ADDR_ASYNC_HI_CLR);
  assign hit_async_lo_set = (paddr == filt_pkg::ADDR_ASYNC_LO_SET);
  assign hit_async_lo_clr = (paddr == filt_pkg::ADDR_ASYNC_LO_CLR);
  assign hit_phys_hi_set  = (paddr == filt_pkg::ADDR_PHYS_HI_SET);
  assign hit_phys_hi_clr  = (paddr == filt_pkg::ADDR_PHYS_HI_CLR);
  assign hit_accept_cnt   = (paddr == filt_pkg::ADDR_ACCEPT_CNT);
  assign hit_reject_cnt   = (paddr == filt_pkg::ADDR_REJECT_CNT);
  assign hit_last_dec     = (paddr == filt_pkg::ADDR_LAST_DEC);
  assign hit_any = hit_async_hi_set | hit_async_hi_clr | hit_async_lo_set
                 | hit_async_lo_clr | hit_phys_hi_set | hit_phys_hi_clr
                 | hit_accept_cnt | hit_reject_cnt | hit_last_dec;

  // Write strobes per address; only a committed, mapped write moves a filter
  // Full 12-bit compare above, so no alias can reach a filter by accident
  wire logic set_async_hi;
  wire logic clr_async_hi;
  wire logic set_async_lo;
  wire logic clr_async_lo;
  wire logic set_phys_hi;
  wire logic clr_phys_hi;
  assign set_async_hi = wr_commit & hit_async_hi_set;
  assign clr_async_hi = wr_commit & hit_async_hi_clr;
  assign set_async_lo = wr_commit & hit_async_lo_set;
  assign clr_async_lo = wr_commit & hit_async_lo_clr;
  assign set_phys_hi  = wr_commit & hit_phys_hi_set;
  assign clr_phys_hi  = wr_commit & hit_phys_hi_clr;

  // Both addresses of a pair read back the same contents
  assign rd_mux = (hit_async_hi_set | hit_async_hi_clr) ? async_hi_ff
                : (hit_async_lo_set | hit_async_lo_clr) ? async_lo_ff
                : (hit_phys_hi_set  | hit_phys_hi_clr)  ? phys_hi_ff
                : hit_accept_cnt ? accept_cnt_ff
                : hit_reject_cnt ? reject_cnt_ff
                : hit_last_dec   ? last_dec_ff
                : filt_pkg::RDATA_ZERO;

  // Bus slave: one wait state, answer registered in the first access cycle
  always_comb begin
    nxt_state   = state_ff;
    nxt_pready  = 1'b0;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = 1'b0;
    unique case (state_ff)
      filt_pkg::APB_WAIT: begin
        if (acc_phase) begin
          nxt_state   = filt_pkg::APB_ANSWER;
          nxt_pready  = 1'b1;
          nxt_pslverr = ~hit_any;
          nxt_prdata  = (pwrite | ~hit_any) ? filt_pkg::RDATA_ZERO : rd_mux;
        end
      end
      filt_pkg::APB_ANSWER: begin
        nxt_state = filt_pkg::APB_WAIT;
      end
    endcase
  end

  // Link reset clears the filters but spares the remote-bus physical bit
  wire logic [31:0] phys_keep;
  assign phys_keep = {phys_hi_ff[filt_pkg::REMOTE_BIT],
                      filt_pkg::FILT_RESET[filt_pkg::REMOTE_BIT-1:0]};

  always_comb begin
    if (link_reset_signal) begin
      nxt_async_hi = filt_pkg::FILT_RESET;
      nxt_async_lo = filt_pkg::FILT_RESET;
      nxt_phys_hi  = phys_keep;
    end else begin
      // Link reset has priority: a write in the same cycle is lost
      nxt_async_hi = rsc_next(async_hi_ff, wbits, set_async_hi,
                              clr_async_hi);
      nxt_async_lo = rsc_next(async_lo_ff, wbits, set_async_lo,
                              clr_async_lo);
      nxt_phys_hi  = rsc_next(phys_hi_ff, wbits, set_phys_hi,
                              clr_phys_hi);
    end
  end

  // Filter decision; sees registered filters, so a write counts one cycle later
  logic             dec_accept_c;
  filt_pkg::route_t dec_route_c;

  node_filter_decide u_decide (
    .src_node   (req_src_node),
    .src_local  (req_src_local),
    .to_phys    (req_to_phys),
    .async_low  (async_lo_ff),
    .async_high (async_hi_ff),
    .phys_low   (phys_filter_low),
    .phys_high  (phys_hi_ff),
    .accept     (dec_accept_c),
    .route      (dec_route_c)
  );

  // Counters: a write clears; a decision in the same cycle still counts
  wire logic cnt_clr_acc;
  wire logic cnt_clr_rej;
  wire logic inc_acc;
  wire logic inc_rej;
  assign cnt_clr_acc = wr_commit & hit_accept_cnt;
  assign cnt_clr_rej = wr_commit & hit_reject_cnt;
  assign inc_acc     = req_valid & dec_accept_c;
  assign inc_rej     = req_valid & ~dec_accept_c;

  always_comb begin
    nxt_accept_cnt = cnt_clr_acc ? filt_pkg::CNT_RESET : accept_cnt_ff;
    nxt_reject_cnt = cnt_clr_rej ? filt_pkg::CNT_RESET : reject_cnt_ff;
    if (inc_acc) begin
      nxt_accept_cnt = nxt_accept_cnt + filt_pkg::CNT_ONE;
    end
    if (inc_rej) begin
      nxt_reject_cnt = nxt_reject_cnt + filt_pkg::CNT_ONE;
    end
  end

  always_comb begin
    nxt_last_dec = last_dec_ff;
    if (req_valid) begin
      nxt_last_dec = filt_pkg::RDATA_ZERO;
      nxt_last_dec[filt_pkg::LAST_ROUTE_LSB +: 2] = dec_route_c;
      nxt_last_dec[filt_pkg::LAST_ACCEPT_BIT]     = dec_accept_c;
      nxt_last_dec[filt_pkg::LAST_NODE_LSB +: 6]  = req_src_node;
      nxt_last_dec[filt_pkg::LAST_LOCAL_BIT]      = req_src_local;
      nxt_last_dec[filt_pkg::LAST_PHYS_BIT]       = req_to_phys;
    end
  end

  // One block per filter; presetn clears all, link reset is folded in above
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_hi_ff <= filt_pkg::FILT_RESET;
    end else begin
      async_hi_ff <= nxt_async_hi;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_lo_ff <= filt_pkg::FILT_RESET;
    end else begin
      async_lo_ff <= nxt_async_lo;
    end
  end

  // Only presetn and bus writes reach the remote-bus bit; link reset must not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phys_hi_ff <= filt_pkg::FILT_RESET;
    end else begin
      phys_hi_ff <= nxt_phys_hi;
    end
  end

  // Bus slave handshake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= filt_pkg::APB_WAIT;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Read data held between transfers; only a new access replaces it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= filt_pkg::RDATA_ZERO;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  // Counters wrap to zero after all ones; software reads and clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accept_cnt_ff <= filt_pkg::CNT_RESET;
    end else begin
      accept_cnt_ff <= nxt_accept_cnt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reject_cnt_ff <= filt_pkg::CNT_RESET;
    end else begin
      reject_cnt_ff <= nxt_reject_cnt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_dec_ff <= filt_pkg::RDATA_ZERO;
    end else begin
      last_dec_ff <= nxt_last_dec;
    end
  end

  // Decision valid for one cycle per request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_valid_ff <= 1'b0;
    end else begin
      dec_valid_ff <= req_valid;
    end
  end

  // Payload forced idle between requests so a stale route never shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_accept_ff <= 1'b0;
      dec_route_ff  <= filt_pkg::ROUTE_NONE;
    end else begin
      dec_accept_ff <= req_valid & dec_accept_c;
      dec_route_ff  <= req_valid ? dec_route_c : filt_pkg::ROUTE_NONE;
    end
  end

  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign dec_valid  = dec_valid_ff;
  assign dec_accept = dec_accept_ff;
  assign dec_route  = dec_route_ff;

endmodule
`default_nettype wire

/* filt_pkg.sv */
`default_nettype none
package filt_pkg;
  localparam int unsigned  DATA_W         = 32;
  localparam int unsigned  ADDR_W         = 12;
  localparam int unsigned  NODE_W         = 6;
  localparam int unsigned  STRB_W         = 4;
  localparam logic [31:0]  FILT_RESET     = 32'h0000_0000;
  localparam int unsigned  REMOTE_BIT     = 31;
  localparam logic [5:0]   NODE_BCAST     = 6'h3f;
  localparam int unsigned  LOW_SEL_BIT    = 5;
  // Byte addresses of the filter pairs
  localparam logic [11:0]  ADDR_ASYNC_HI_SET  = 12'h100;
  localparam logic [11:0]  ADDR_ASYNC_HI_CLR  = 12'h104;
  localparam logic [11:0]  ADDR_ASYNC_LO_SET  = 12'h108;
  localparam logic [11:0]  ADDR_ASYNC_LO_CLR  = 12'h10c;
  localparam logic [11:0]  ADDR_PHYS_HI_SET   = 12'h110;
  localparam logic [11:0]  ADDR_PHYS_HI_CLR   = 12'h114;
  // Decision statistics
  localparam logic [11:0]  ADDR_ACCEPT_CNT    = 12'h120;
  localparam logic [11:0]  ADDR_REJECT_CNT    = 12'h124;
  localparam logic [11:0]  ADDR_LAST_DEC      = 12'h128;
  localparam logic [31:0]  CNT_RESET          = 32'h0000_0000;
  localparam logic [31:0]  CNT_ONE            = 32'h0000_0001;
  localparam logic [31:0]  RDATA_ZERO         = 32'h0000_0000;
  // Last decision layout
  localparam int unsigned  LAST_ROUTE_LSB     = 0;
  localparam int unsigned  LAST_ACCEPT_BIT    = 2;
  localparam int unsigned  LAST_NODE_LSB      = 8;
  localparam int unsigned  LAST_LOCAL_BIT     = 16;
  localparam int unsigned  LAST_PHYS_BIT      = 17;

  typedef enum logic [1:0] {
    ROUTE_NONE  = 2'b00,
    ROUTE_ASYNC = 2'b01,
    ROUTE_PHYS  = 2'b10
  } route_t;

  typedef enum logic {
    APB_WAIT   = 1'b0,
    APB_ANSWER = 1'b1
  } apb_state_t;

  function automatic logic filt_bit(input logic [31:0] vec, input logic [4:0] idx);
    filt_bit = vec[idx];
  endfunction
endpackage
`default_nettype wire

/* node_filter_decide.sv */
`timescale 1ns/10ps
`default_nettype none
module node_filter_decide (
  input  wire logic [5:0]  src_node,
  input  wire logic        src_local,
  input  wire logic        to_phys,
  input  wire logic [31:0] async_low,
  input  wire logic [31:0] async_high,
  input  wire logic [31:0] phys_low,
  input  wire logic [31:0] phys_high,
  output logic             accept,
  output filt_pkg::route_t route
);
  wire logic       in_low;
  wire logic       is_bcast;
  wire logic [4:0] idx;
  wire logic       async_bit;
  wire logic       phys_bit;
  wire logic       remote_phys_ok;
  wire logic       remote_async_ok;
  wire logic       go_phys;

  assign in_low   = ~src_node[filt_pkg::LOW_SEL_BIT];
  assign is_bcast = (src_node == filt_pkg::NODE_BCAST);
  // Upper nodes 32..62 index by their low five bits
  assign idx      = src_node[4:0];
  assign async_bit = in_low ? filt_pkg::filt_bit(async_low, idx)
                            : (~is_bcast & filt_pkg::filt_bit(async_high, idx));
  assign phys_bit  = in_low ? filt_pkg::filt_bit(phys_low, idx)
                            : (~is_bcast & filt_pkg::filt_bit(phys_high, idx));
  assign remote_phys_ok  = phys_high[filt_pkg::REMOTE_BIT];
  assign remote_async_ok = async_high[filt_pkg::REMOTE_BIT] | remote_phys_ok;
  // Per-node compare only for local sources; remote uses the bus-wide bits
  assign accept = src_local ? async_bit
                            : (to_phys ? remote_phys_ok : remote_async_ok);
  // Second compare against the physical filter, falling back to async
  assign go_phys = to_phys & (src_local ? phys_bit : 1'b1);
  assign route   = ~accept ? filt_pkg::ROUTE_NONE
                 : (go_phys ? filt_pkg::ROUTE_PHYS : filt_pkg::ROUTE_ASYNC);
endmodule
`default_nettype wire

/* request_node_filter_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module request_node_filter_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        req_valid,
  input wire logic [5:0]  req_src_node,
  input wire logic        req_src_local,
  input wire logic        req_to_phys,
  input wire logic        dec_valid,
  input wire logic        dec_accept,
  input wire logic [1:0]  dec_route
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic mapped;
  assign mapped = paddr inside {12'h100, 12'h104, 12'h108, 12'h10c, 12'h110, 12'h114,
                                12'h120, 12'h124, 12'h128};
  sequence access_wait;
    psel && penable && !pready;
  endsequence
  sequence remote_req(logic ph);
    req_valid && !req_src_local && (req_to_phys == ph);
  endsequence
  sequence local_req(logic ph);
    req_valid && req_src_local && (req_to_phys == ph);
  endsequence
  rdy_after_wait_a: assert property (access_wait |=> pready)
    else $error("pready missing after access");
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_unmapped_a: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  err_with_rdy_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  dec_timing_a: assert property (req_valid |=> dec_valid)
    else $error("decision missing");
  dec_spurious_a: assert property (!req_valid |=> !dec_valid)
    else $error("decision without request");
  idle_quiet_a: assert property (!dec_valid |-> !dec_accept && dec_route == 2'b00)
    else $error("decision outputs not idle");
  accept_route_a: assert property (dec_valid |-> dec_accept == (dec_route != 2'b00))
    else $error("accept and route disagree");
  remote_phys_a: assert property (remote_req(1'b1) |=> !dec_accept || dec_route == 2'b10)
    else $error("remote physical request misrouted");
  remote_async_a: assert property (remote_req(1'b0) |=> !dec_accept || dec_route == 2'b01)
    else $error("remote async request misrouted");
  node_top_a: assert property (req_valid && req_src_local && req_src_node == 6'h3f |=> !dec_accept)
    else $error("node 63 accepted");
  local_async_a: assert property (local_req(1'b0) |=> dec_route != 2'b10)
    else $error("local async request routed physical");
endmodule
bind request_node_filter request_node_filter_chk chk (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .req_valid, .req_src_node, .req_src_local, .req_to_phys,
  .dec_valid, .dec_accept, .dec_route);
`default_nettype wire

/* remote_nodes.sv */
`timescale 1ns/10ps
`default_nettype none
module remote_nodes (
  input  wire logic       pclk,
  output logic            req_valid,
  output logic [5:0]      req_src_node,
  output logic            req_src_local,
  output logic            req_to_phys
);
  initial begin
    req_valid = 1'b0;
    req_src_node = 6'h00;
    req_src_local = 1'b0;
    req_to_phys = 1'b0;
  end
  // Call right after a rising edge; one request per call
  task automatic send(input logic [5:0] nd, input logic loc, input logic ph);
    req_valid <= 1'b1;
    req_src_node <= nd;
    req_src_local <= loc;
    req_to_phys <= ph;
    @(posedge pclk);
    req_valid <= 1'b0;
    // Node and phys fields scrambled after the pulse so stale values are never trusted; src_local is left as sent
    req_src_node <= ~nd;
    req_to_phys <= ~ph;
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, link_reset_signal, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, phys_filter_low, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, req_valid, req_src_local, req_to_phys;
  logic        dec_valid, dec_accept;
  logic [5:0]  req_src_node;
  logic [1:0]  dec_route;
  int          mismatches, n_checks;
  logic [11:0] regs [4] = '{12'h108, 12'h10c, 12'h110, 12'h114};
  request_node_filter uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .link_reset_signal, .req_valid, .req_src_node, .req_src_local,
    .req_to_phys, .phys_filter_low, .dec_valid, .dec_accept, .dec_route);
  remote_nodes partner (.pclk, .req_valid, .req_src_node, .req_src_local, .req_to_phys);
  task automatic results();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int   n;
    logic seen;
    n = 0;
    seen = 1'b0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer looked at mid-cycle; request still held through the edge that ends it
    while (!seen && n < 50) begin
      @(negedge pclk);
      seen = (pready === 1'b1);
      rd = prdata;
      err = pslverr;
      @(posedge pclk);
      n++;
    end
    if (!seen) mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic req(input logic [5:0] nd, input logic loc, input logic ph,
                     input logic acc, input logic [1:0] rt);
    partner.send(nd, loc, ph);
    @(negedge pclk);
    chk({31'h0, dec_valid}, 32'h1);
    chk({31'h0, dec_accept}, {31'h0, acc});
    chk({30'h0, dec_route}, {30'h0, rt});
    @(posedge pclk);
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #20000;
    mismatches++;
    results();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    link_reset_signal = 1'b0;
    phys_filter_low = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h0, 4'hf);
      chk(rd, 32'h0);
    end
    req(6'd0, 1'b1, 1'b0, 1'b0, 2'b00);
    req(6'd5, 1'b0, 1'b1, 1'b0, 2'b00);
    req(6'd5, 1'b0, 1'b0, 1'b0, 2'b00);
    apb(1'b1, 12'h108, 32'h8000_0001, 4'hf);
    apb(1'b1, 12'h108, 32'h0, 4'hf);
    apb(1'b0, 12'h10c, 32'h0, 4'hf);
    chk(rd, 32'h8000_0001);
    req(6'd31, 1'b1, 1'b0, 1'b1, 2'b01);
    req(6'd63, 1'b1, 1'b0, 1'b0, 2'b00);
    apb(1'b1, 12'h10c, 32'h0000_0001, 4'hf);
    apb(1'b0, 12'h108, 32'h0, 4'hf);
    chk(rd, 32'h8000_0000);
    req(6'd0, 1'b1, 1'b0, 1'b0, 2'b00);
    apb(1'b1, 12'h108, 32'hffff_ffff, 4'h1);
    apb(1'b0, 12'h108, 32'h0, 4'hf);
    chk(rd, 32'h8000_00ff);
    apb(1'b1, 12'h100, 32'h0000_0001, 4'hf);
    apb(1'b1, 12'h110, 32'h8000_0001, 4'hf);
    apb(1'b0, 12'h114, 32'h0, 4'hf);
    chk(rd, 32'h8000_0001);
    req(6'd32, 1'b1, 1'b1, 1'b1, 2'b10);
    req(6'd31, 1'b1, 1'b1, 1'b1, 2'b01);
    phys_filter_low <= 32'h8000_0000;
    req(6'd31, 1'b1, 1'b1, 1'b1, 2'b10);
    req(6'd7, 1'b0, 1'b1, 1'b1, 2'b10);
    req(6'd7, 1'b0, 1'b0, 1'b1, 2'b01);
    link_reset_signal <= 1'b1;
    @(posedge pclk);
    link_reset_signal <= 1'b0;
    apb(1'b0, 12'h110, 32'h0, 4'hf);
    chk(rd, 32'h8000_0000);
    apb(1'b0, 12'h108, 32'h0, 4'hf);
    chk(rd, 32'h0);
    req(6'd7, 1'b0, 1'b1, 1'b1, 2'b10);
    apb(1'b1, 12'h114, 32'h8000_0000, 4'hf);
    req(6'd7, 1'b0, 1'b1, 1'b0, 2'b00);
    // Thirteen decisions so far: seven accepted, six refused
    apb(1'b0, 12'h120, 32'h0, 4'hf);
    chk(rd, 32'h0000_0007);
    apb(1'b0, 12'h124, 32'h0, 4'hf);
    chk(rd, 32'h0000_0006);
    apb(1'b0, 12'h128, 32'h0, 4'hf);
    chk(rd, 32'h0002_0700);
    apb(1'b1, 12'h120, 32'h0, 4'hf);
    apb(1'b0, 12'h120, 32'h0, 4'hf);
    chk(rd, 32'h0);
    // Mid-run reset clears even the bit that link reset spares
    apb(1'b1, 12'h110, 32'h8000_0000, 4'hf);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h110, 32'h0, 4'hf);
    chk(rd, 32'h0);
    apb(1'b0, 12'h200, 32'h0, 4'hf);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    results();
  end
endmodule
`default_nettype wire
